// *** core/capture_defs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH
`define OFS_SYNC_ENABLE 12'h000
`define OFS_MODE_SETUP 12'h004
`define SYNC_RESET 2'h0
`define MODE_RESET 16'h2000
`define SYNC_WMASK 16'h0003
`define MODE_WMASK 16'h77ff
`define B_GEN_EN 0
`define B_WR_EN 1
`define B_FIELD_ST 15
`define B_LPF 14
`define F_FMT 13:12
`define F_SHIFT 10:8
`define B_ILACE 7
`define B_INV 6
`define B_GATE 5
`define B_FPOL 4
`define B_HPOL 3
`define B_VPOL 2
`define B_FDIR 1
`define B_SDIR 0
`define SHIFT_MAX 3'h4
`define GEN_LINE_LEN 16'h0359
`define GEN_FRAME_LINES 16'h020c
`define GEN_HS_WIDTH 16'h003f
`define GEN_VS_WIDTH 16'h0005
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** core/capture_pkg.sv ***
// Types shared by the capture control design
package capture_pkg;
    typedef enum logic [1:0] {FMT_RAW, FMT_YCC16, FMT_YCC8, FMT_RSVD} fmt_e;
    typedef enum logic [1:0] {SEL_SYNC, SEL_MODE, SEL_NONE} sel_e;
    typedef struct packed {
        logic [1:0] sync;
        logic [15:0] mode;
    } cfg_s;
    typedef struct packed {
        logic aw_got;
        logic [11:0] awaddr;
        logic w_got;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic [1:0] sync_en;
        logic [15:0] mode;
        logic req;
        cfg_s shadow;
    } bus_s;
    typedef struct packed {
        logic ack;
        cfg_s cfg;
        logic vs_prev;
        logic hs_prev;
        logic [15:0] h;
        logic [15:0] v;
        logic wr_lat;
        logic lpf_lat;
        logic fld_gen;
        logic field;
        logic wv0;
        logic wv;
        logic hs_o;
        logic vs_o;
        logic fld_o;
    } pix_s;
    typedef struct packed {
        logic [15:0] t1;
        logic [15:0] t2;
        logic [15:0] out;
    } cond_s;
endpackage

// *** core/sync_sampler.sv ***
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ns
module sync_sampler #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;
    sync_s s_r, s_nxt;
    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= {RST, RST};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign q = s_r.s2;
endmodule

// *** core/pixel_condition.sv ***
// Pixel data conditioning: inversion, three-tap filter, raw shift
`timescale 1ns/1ns
`include "capture_defs.svh"
module pixel_condition (
    input wire logic pix_clk,
    input wire logic reset,
    input wire logic [15:0] raw_in,
    input wire logic invert,
    input wire logic lpf_on,
    input wire capture_pkg::fmt_e fmt,
    input wire logic [2:0] shift_code,
    output logic [15:0] data_out
);
    import capture_pkg::*;
    cond_s c_r, c_nxt;
    logic [15:0] x;
    logic [15:0] f;
    logic [17:0] sum;
    always_comb begin
        c_nxt = c_r;
        x = invert ? ~raw_in : raw_in;
        sum = {2'h0, x} + {1'h0, c_r.t1, 1'h0} + {2'h0, c_r.t2};
        f = lpf_on ? sum[17:2] : c_r.t1;
        c_nxt.t1 = x;
        c_nxt.t2 = c_r.t1;
        // Reserved shift codes fall back to no shift
        if (fmt == FMT_RAW && shift_code <= `SHIFT_MAX) begin
            c_nxt.out = f >> shift_code;
        end else begin
            c_nxt.out = f;
        end
    end
    always_ff @(posedge pix_clk or posedge reset) begin
        if (reset) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end
    assign data_out = c_r.out;

    property p_pass_or_invert;
        @(posedge pix_clk) disable iff (reset)
        $past(!lpf_on && fmt != FMT_RAW) |-> data_out == ($past(raw_in, 2) ^ {16{$past(invert, 2)}});
    endproperty
    a_pass_or_invert: assert property (p_pass_or_invert) else $error("data not passed or inverted");
    property p_raw_shift;
        @(posedge pix_clk) disable iff (reset)
        $past(!lpf_on && fmt == FMT_RAW && shift_code <= 3'h4) && !$past(invert, 2)
            |-> data_out == ($past(raw_in, 2) >> $past(shift_code));
    endproperty
    a_raw_shift: assert property (p_raw_shift) else $error("raw shift wrong");
endmodule

// *** core/sensor_sync_mode_control.sv ***
// Capture sync and mode control: register slave, timing generator, write gating
`timescale 1ns/1ns
`include "capture_defs.svh"
// Notes on behaviour
// - Outside external gate mode, captured data goes to memory only while the capture write enable is set.
// - A new capture write enable value takes effect only at a vertical sync start.
// - With syncs as outputs, the generator enable starts the timing generator that drives them.
// - With syncs as inputs, the generator enable starts the generator locked to the incoming syncs.
// - The low-pass bit applies a 1/4, 1/2, 1/4 horizontal filter and is taken at vertical sync.
// - Raw data is shifted right by codes 0 to 4; codes 5 to 7 are reserved and give no shift.
// - The raw shift applies only when the input format is raw; YCbCr formats ignore it.
// - Data invert off passes samples unchanged; on replaces each with its ones complement.
// - External gate select with the generator enabled makes the gate pin the memory write enable.
// - In external gate mode data is stored only while both syncs, incoming or generated, are active.
// - The field flag direction bit makes the field pin an input at 0 and an output at 1.
// - Sync direction 0 makes both syncs inputs; 1 makes the device drive both.
module sensor_sync_mode_control (
    input wire logic clk,
    input wire logic reset,
    input wire logic pix_clk,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic horizontal_sync_in,
    output logic horizontal_sync_out,
    output logic horizontal_sync_oe,
    input wire logic vertical_sync_in,
    output logic vertical_sync_out,
    output logic vertical_sync_oe,
    input wire logic field_in,
    output logic field_out,
    output logic field_oe,
    input wire logic write_gate_in,
    input wire logic [15:0] pixel_in,
    output logic mem_wr_valid,
    output logic [15:0] mem_wr_data
);
    import capture_pkg::*;

    localparam cfg_s CFG_INIT = '{sync: `SYNC_RESET, mode: `MODE_RESET};
    localparam bus_s BUS_INIT = '{default: '0, mode: `MODE_RESET, shadow: CFG_INIT};

    function automatic sel_e reg_sel(input logic [11:0] a);
        if (a[11:2] == `OFS_SYNC_ENABLE >> 2) begin
            reg_sel = SEL_SYNC;
        end else if (a[11:2] == `OFS_MODE_SETUP >> 2) begin
            reg_sel = SEL_MODE;
        end else begin
            reg_sel = SEL_NONE;
        end
    endfunction

    bus_s b_r, b_nxt;
    logic aw_fire, w_fire, ar_fire, have_aw, have_w;
    logic [11:0] wa;
    logic [15:0] wd, old, merged, wmask;
    logic [1:0] ws;
    cfg_s live;
    logic [1:0] back_s;
    logic ack_s, field_s;

    assign awready = !b_r.aw_got && !b_r.bvalid;
    assign wready = !b_r.w_got && !b_r.bvalid;
    assign arready = !b_r.rvalid;
    assign aw_fire = awvalid && awready;
    assign w_fire = wvalid && wready;
    assign ar_fire = arvalid && arready;
    assign live = '{sync: b_r.sync_en, mode: b_r.mode};
    assign ack_s = back_s[1];
    assign field_s = back_s[0];

    always_comb begin
        b_nxt = b_r;
        have_aw = b_r.aw_got || aw_fire;
        have_w = b_r.w_got || w_fire;
        wa = b_r.aw_got ? b_r.awaddr : awaddr;
        wd = b_r.w_got ? b_r.wdata : wdata[15:0];
        ws = b_r.w_got ? b_r.wstrb : wstrb[1:0];
        old = (reg_sel(wa) == SEL_SYNC) ? {14'h0, b_r.sync_en} : b_r.mode;
        wmask = (reg_sel(wa) == SEL_SYNC) ? `SYNC_WMASK : `MODE_WMASK;
        merged = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]} & wmask;
        if (aw_fire) begin
            b_nxt.aw_got = 1'b1;
            b_nxt.awaddr = awaddr;
        end
        if (w_fire) begin
            b_nxt.w_got = 1'b1;
            b_nxt.wdata = wdata[15:0];
            b_nxt.wstrb = wstrb[1:0];
        end
        if (b_r.bvalid && bready) begin
            b_nxt.bvalid = 1'b0;
        end
        // Address and data may arrive in either order; write once both are held
        if (have_aw && have_w) begin
            b_nxt.aw_got = 1'b0;
            b_nxt.w_got = 1'b0;
            b_nxt.bvalid = 1'b1;
            b_nxt.bresp = `RESP_OKAY;
            case (reg_sel(wa))
                SEL_SYNC: begin
                    b_nxt.sync_en = merged[1:0];
                end
                SEL_MODE: begin
                    b_nxt.mode = merged;
                end
                default: begin
                    b_nxt.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (b_r.rvalid && rready) begin
            b_nxt.rvalid = 1'b0;
        end
        if (ar_fire) begin
            b_nxt.rvalid = 1'b1;
            b_nxt.rresp = `RESP_OKAY;
            case (reg_sel(araddr))
                SEL_SYNC: begin
                    b_nxt.rdata = {14'h0, b_r.sync_en};
                end
                SEL_MODE: begin
                    b_nxt.rdata = {field_s, b_r.mode[14:0]};
                end
                default: begin
                    b_nxt.rdata = 16'h0;
                    b_nxt.rresp = `RESP_SLVERR;
                end
            endcase
        end
        // Shadow stays frozen while the link side may still be copying it
        if (b_r.req == ack_s && b_r.shadow != live) begin
            b_nxt.shadow = live;
            b_nxt.req = !b_r.req;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            b_r <= BUS_INIT;
        end else begin
            b_r <= b_nxt;
        end
    end

    assign bvalid = b_r.bvalid;
    assign bresp = b_r.bresp;
    assign rvalid = b_r.rvalid;
    assign rresp = b_r.rresp;
    assign rdata = {16'h0, b_r.rdata};

    pix_s p_r, p_nxt;
    logic [19:0] pin_s;
    logic [15:0] m;
    logic req_s, pix_run, pix_rst;
    logic en, sdir, fdir, ext, hs_in, vs_in, fld_in, gate_in;
    logic hs_gen, vs_gen, hs_act, vs_act, vs_start, hs_start, wr;

    // Link reset asserts at once and releases on a pixel clock edge
    sync_sampler #(.W(1), .RST(1'b0)) u_pix_reset (
        .clk(pix_clk),
        .reset(reset),
        .d(1'b1),
        .q(pix_run)
    );
    assign pix_rst = !pix_run;

    sync_sampler #(.W(21), .RST(21'h0)) u_pin_sync (
        .clk(pix_clk),
        .reset(pix_rst),
        .d({b_r.req, horizontal_sync_in, vertical_sync_in, field_in, write_gate_in, pixel_in}),
        .q({req_s, pin_s})
    );

    sync_sampler #(.W(2), .RST(2'h0)) u_back_sync (
        .clk(clk),
        .reset(reset),
        .d({p_r.ack, p_r.field}),
        .q(back_s)
    );

    assign m = p_r.cfg.mode;
    assign en = p_r.cfg.sync[`B_GEN_EN];
    assign sdir = m[`B_SDIR];
    assign fdir = m[`B_FDIR];
    assign hs_in = pin_s[19] ^ m[`B_HPOL];
    assign vs_in = pin_s[18] ^ m[`B_VPOL];
    assign fld_in = pin_s[17] ^ m[`B_FPOL];
    assign gate_in = pin_s[16];
    assign hs_gen = en && (p_r.h <= `GEN_HS_WIDTH);
    assign vs_gen = en && (p_r.v <= `GEN_VS_WIDTH);
    assign hs_act = sdir ? hs_gen : hs_in;
    assign vs_act = sdir ? vs_gen : vs_in;
    assign vs_start = vs_act && !p_r.vs_prev;
    assign hs_start = hs_in && !p_r.hs_prev;
    assign ext = m[`B_GATE] && en;
    assign wr = ext ? (gate_in && hs_act && vs_act) : (p_r.wr_lat && en && hs_act && vs_act);

    always_comb begin
        p_nxt = p_r;
        if (req_s != p_r.ack) begin
            p_nxt.cfg = b_r.shadow;
            p_nxt.ack = req_s;
        end
        p_nxt.vs_prev = vs_act;
        p_nxt.hs_prev = hs_in;
        if (!en) begin
            p_nxt.h = 16'h0;
            p_nxt.v = 16'h0;
        end else if (!sdir && vs_start) begin
            p_nxt.h = 16'h0;
            p_nxt.v = 16'h0;
        end else if (!sdir && hs_start) begin
            p_nxt.h = 16'h0;
            p_nxt.v = p_r.v + 16'h1;
        end else if (p_r.h == `GEN_LINE_LEN) begin
            p_nxt.h = 16'h0;
            p_nxt.v = (p_r.v == `GEN_FRAME_LINES) ? 16'h0 : p_r.v + 16'h1;
        end else begin
            p_nxt.h = p_r.h + 16'h1;
        end
        if (vs_start) begin
            p_nxt.wr_lat = p_r.cfg.sync[`B_WR_EN];
            p_nxt.lpf_lat = m[`B_LPF];
            p_nxt.fld_gen = !p_r.fld_gen;
        end
        p_nxt.field = fdir ? p_r.fld_gen : fld_in;
        // Valid is delayed twice to line up with the conditioning pipeline
        p_nxt.wv0 = wr;
        p_nxt.wv = p_r.wv0;
        p_nxt.hs_o = hs_gen ^ m[`B_HPOL];
        p_nxt.vs_o = vs_gen ^ m[`B_VPOL];
        // Uses the next field value so the pin flips on the same edge as the frame sync
        p_nxt.fld_o = p_nxt.fld_gen ^ m[`B_FPOL];
    end

    always_ff @(posedge pix_clk or posedge pix_rst) begin
        if (pix_rst) begin
            p_r <= '{default: '0, cfg: CFG_INIT};
        end else begin
            p_r <= p_nxt;
        end
    end

    pixel_condition u_cond (
        .pix_clk(pix_clk),
        .reset(pix_rst),
        .raw_in(pin_s[15:0]),
        .invert(m[`B_INV]),
        .lpf_on(p_r.lpf_lat),
        .fmt(fmt_e'(m[`F_FMT])),
        .shift_code(m[`F_SHIFT]),
        .data_out(mem_wr_data)
    );

    assign mem_wr_valid = p_r.wv;
    assign horizontal_sync_out = p_r.hs_o;
    assign vertical_sync_out = p_r.vs_o;
    assign horizontal_sync_oe = sdir;
    assign vertical_sync_oe = sdir;
    assign field_out = p_r.fld_o;
    assign field_oe = fdir;

    property p_bresp_held;
        @(posedge clk) disable iff (reset)
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bresp_held: assert property (p_bresp_held) else $error("write response dropped");
    property p_field_read;
        @(posedge clk) disable iff (reset)
        ar_fire && reg_sel(araddr) == SEL_MODE |=> rvalid && rdata[15] == $past(field_s);
    endproperty
    a_field_read: assert property (p_field_read) else $error("field status not read back");
    property p_wr_lat_vsync;
        @(posedge pix_clk) disable iff (pix_rst)
        p_r.wr_lat != $past(p_r.wr_lat) |-> $past(vs_start);
    endproperty
    a_wr_lat_vsync: assert property (p_wr_lat_vsync) else $error("write enable moved off vsync");
    property p_lpf_vsync;
        @(posedge pix_clk) disable iff (pix_rst)
        p_r.lpf_lat != $past(p_r.lpf_lat) |-> $past(vs_start);
    endproperty
    a_lpf_vsync: assert property (p_lpf_vsync) else $error("filter bit moved off vsync");
    property p_internal_gate;
        @(posedge pix_clk) disable iff (pix_rst)
        p_r.wv0 && !$past(ext) |-> $past(p_r.wr_lat && en && hs_act && vs_act);
    endproperty
    a_internal_gate: assert property (p_internal_gate) else $error("write without enable");
    property p_external_gate;
        @(posedge pix_clk) disable iff (pix_rst)
        p_r.wv0 && $past(ext) |-> $past(gate_in && hs_act && vs_act);
    endproperty
    a_external_gate: assert property (p_external_gate) else $error("gate write outside syncs");
    property p_gen_idle;
        @(posedge pix_clk) disable iff (pix_rst)
        !en |=> p_r.h == 16'h0 && p_r.v == 16'h0 && !p_r.wv0;
    endproperty
    a_gen_idle: assert property (p_gen_idle) else $error("generator ran while disabled");
    sequence s_lock;
        en && !sdir && vs_start;
    endsequence
    property p_lock;
        @(posedge pix_clk) disable iff (pix_rst)
        s_lock |=> p_r.h == 16'h0 && p_r.v == 16'h0 ##1 p_r.h <= 16'h1;
    endproperty
    a_lock: assert property (p_lock) else $error("generator not locked to vsync");
endmodule

// *** tb/sensor_model.sv ***
// Behavioural camera sensor: input syncs, field flag, write gate and pixel data
`timescale 1ns/1ns
module sensor_model #(
    parameter logic [15:0] LEVEL = 16'ha5c3,
    parameter logic [15:0] LOW = 16'h0100,
    parameter logic [15:0] HIGH = 16'h0300
) (
    input wire logic pix_clk,
    input wire logic reset,
    input wire logic hs_neg,
    input wire logic vs_neg,
    input wire logic alt,
    input wire logic fld,
    output logic horizontal_sync,
    output logic vertical_sync,
    output logic field,
    output logic gate,
    output logic [15:0] pixel,
    output logic [15:0] frames
);
    logic [3:0] h_r;
    logic [2:0] v_r;
    // Tiny raster, 16 clocks a line and 8 lines a frame, keeps each frame short
    always_ff @(posedge pix_clk or posedge reset) begin
        if (reset) begin
            h_r <= 4'h0;
            v_r <= 3'h0;
            frames <= 16'h0;
        end else begin
            h_r <= h_r + 4'h1;
            if (h_r == 4'hf) v_r <= v_r + 3'h1;
            if (h_r == 4'hf && v_r == 3'h7) frames <= frames + 16'h1;
        end
    end
    // Active window is clocks 4 to 11 of lines 1 to 6: 48 samples a frame
    assign horizontal_sync = (h_r >= 4'h4 && h_r <= 4'hb) ^ hs_neg;
    assign vertical_sync = (v_r >= 3'h1 && v_r <= 3'h6) ^ vs_neg;
    assign field = fld;
    // Gate covers only half the active part of a line
    assign gate = h_r >= 4'h4 && h_r <= 4'h7;
    // Pattern keeps toggling in blanking, so no filter tap sees a stale value
    assign pixel = alt ? (h_r[0] ? HIGH : LOW) : LEVEL;
endmodule

// *** tb/sensor_sync_mode_control_tb.sv ***
// Self-checking bench for the capture sync and mode control block
`timescale 1ns/1ns
`include "capture_defs.svh"
module sensor_sync_mode_control_tb;
    typedef struct {logic [1:0] sync; logic [15:0] mode; logic [15:0] data; int count;} row_s;
    localparam logic [15:0] D = 16'ha5c3;
    logic clk = 0, reset = 1, pix_clk = 0, fld = 0, counting = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = '0, strb_v = 4'hf;
    logic f0 = 0;
    logic [15:0] mode_v = '0, exp_data = '0, frames, pixel_in, mem_wr_data;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, mem_wr_valid, write_gate_in, field_in, field_out, field_oe;
    logic horizontal_sync_in, horizontal_sync_out, horizontal_sync_oe;
    logic vertical_sync_in, vertical_sync_out, vertical_sync_oe;
    int fails = 0, n_compared = 0, n_wr = 0, hi, per, n;
    // Interlace bit stays 0 in every row, above all in the gate row
    row_s rows [12] = '{'{2'h3, 16'h0000, D, 48}, '{2'h3, 16'h0300, D >> 3, 48}, '{2'h3, 16'h0400, D >> 4, 48},
        '{2'h3, 16'h0500, D, 48}, '{2'h3, 16'h1300, D, 48}, '{2'h3, 16'h2200, D, 48},
        '{2'h3, 16'h0040, ~D, 48}, '{2'h3, 16'h000c, D, 48}, '{2'h3, 16'h4000, 16'h0200, 48},
        '{2'h1, 16'h0000, D, 0}, '{2'h2, 16'h0000, D, 0}, '{2'h1, 16'h0020, D, 24}};

    sensor_sync_mode_control dut (.clk, .reset, .pix_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .horizontal_sync_in, .horizontal_sync_out, .horizontal_sync_oe, .vertical_sync_in,
        .vertical_sync_out, .vertical_sync_oe, .field_in, .field_out, .field_oe, .write_gate_in, .pixel_in,
        .mem_wr_valid, .mem_wr_data);
    sensor_model model (.pix_clk, .reset, .hs_neg(mode_v[3]), .vs_neg(mode_v[2]), .alt(mode_v[14]), .fld,
        .horizontal_sync(horizontal_sync_in), .vertical_sync(vertical_sync_in), .field(field_in),
        .gate(write_gate_in), .pixel(pixel_in), .frames);

    always #25 clk = ~clk;
    initial begin
        #37;
        forever #80 pix_clk = ~pix_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic bound_hit(input int k, input int lim);
        if (k >= lim) begin
            fails++;
            complete_run;
        end
    endtask
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb_v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        if (k == 50) begin
            fails++;
            complete_run;
        end
        check({30'h0, bresp}, {30'h0, er});
        bready <= 0;
    endtask
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        if (k == 50) begin
            fails++;
            complete_run;
        end
        d = rdata;
        check({30'h0, rresp}, {30'h0, er});
        rready <= 0;
    endtask
    task automatic wait_frame;
        logic [15:0] f0;
        int k;
        f0 = frames;
        for (k = 0; k < 2000 && frames === f0; k++) @(posedge clk);
        if (k == 2000) begin
            fails++;
            complete_run;
        end
    endtask
    task automatic count_frame(input int exp);
        n_wr = 0;
        counting = 1;
        wait_frame;
        counting = 0;
        check(n_wr, exp);
    endtask

    always @(posedge pix_clk) begin
        if (counting && mem_wr_valid === 1'b1) begin
            n_wr++;
            check({16'h0, mem_wr_data}, {16'h0, exp_data});
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 0;
        axi_read(12'h000, rd, `RESP_OKAY);
        check(rd, 32'h0);
        axi_read(12'h004, rd, `RESP_OKAY);
        check(rd, 32'h0000_2000);
        check({29'h0, horizontal_sync_oe, vertical_sync_oe, field_oe}, 32'h0);
        axi_write(12'h004, 32'h0000_775f, `RESP_OKAY);
        axi_read(12'h004, rd, `RESP_OKAY);
        check(rd & 32'h7fff, 32'h775f);
        // Low lane only: the upper byte must keep its old value
        strb_v = 4'h1;
        axi_write(12'h004, 32'h0000_1200, `RESP_OKAY);
        strb_v = 4'hf;
        axi_read(12'h004, rd, `RESP_OKAY);
        check(rd & 32'h7fff, 32'h7700);
        axi_write(12'h008, 32'h1, `RESP_SLVERR);
        axi_read(12'h008, rd, `RESP_SLVERR);
        check(rd, 32'h0);
        axi_write(12'h004, 32'h0, `RESP_OKAY);
        for (n = 1; n >= 0; n--) begin
            fld <= n[0];
            repeat (60) @(posedge clk);
            axi_read(12'h004, rd, `RESP_OKAY);
            check({31'h0, rd[15]}, n);
        end
        $display("test registers done");
        foreach (rows[i]) begin
            mode_v <= rows[i].mode;
            exp_data <= rows[i].data;
            axi_write(12'h004, {16'h0, rows[i].mode}, `RESP_OKAY);
            axi_write(12'h000, {30'h0, rows[i].sync}, `RESP_OKAY);
            wait_frame;
            wait_frame;
            count_frame(rows[i].count);
            $display("test row %0d done", i);
        end
        // Enable written mid-frame must wait for the next frame sync
        mode_v <= 16'h0;
        axi_write(12'h004, 32'h0, `RESP_OKAY);
        axi_write(12'h000, 32'h1, `RESP_OKAY);
        wait_frame;
        wait_frame;
        repeat (48) @(posedge pix_clk);
        axi_write(12'h000, 32'h3, `RESP_OKAY);
        count_frame(0);
        count_frame(48);
        $display("test latch done");
        axi_write(12'h004, 32'h3, `RESP_OKAY);
        repeat (60) @(posedge clk);
        check({29'h0, horizontal_sync_oe, vertical_sync_oe, field_oe}, 32'h7);
        for (n = 0; n < 2000 && horizontal_sync_out !== 1'b0; n++) @(posedge pix_clk);
        bound_hit(n, 2000);
        for (n = 0; n < 2000 && horizontal_sync_out !== 1'b1; n++) @(posedge pix_clk);
        bound_hit(n, 2000);
        for (hi = 0; hi < 2000 && horizontal_sync_out === 1'b1; hi++) @(posedge pix_clk);
        for (per = hi; per < 2000 && horizontal_sync_out !== 1'b1; per++) @(posedge pix_clk);
        bound_hit(per, 2000);
        check(hi, `GEN_HS_WIDTH + 1);
        check(per, `GEN_LINE_LEN + 1);
        // Generator stopped: driven syncs sit at their inactive level
        axi_write(12'h000, 32'h0, `RESP_OKAY);
        axi_write(12'h004, 32'h1f, `RESP_OKAY);
        repeat (60) @(posedge clk);
        check({30'h0, horizontal_sync_out, vertical_sync_out}, 32'h3);
        axi_write(12'h004, 32'h3, `RESP_OKAY);
        repeat (60) @(posedge clk);
        f0 = field_out;
        // Restart from line zero, so the first frame sync is a full pulse
        axi_write(12'h000, 32'h1, `RESP_OKAY);
        for (n = 0; n < 2000 && vertical_sync_out !== 1'b1; n++) @(posedge pix_clk);
        bound_hit(n, 2000);
        for (hi = 0; hi < 6000 && vertical_sync_out === 1'b1; hi++) @(posedge pix_clk);
        bound_hit(hi, 6000);
        check(hi, (`GEN_VS_WIDTH + 1) * (`GEN_LINE_LEN + 1));
        check({31'h0, field_out}, {31'h0, ~f0});
        axi_read(12'h004, rd, `RESP_OKAY);
        check({31'h0, rd[15]}, {31'h0, ~f0});
        $display("test generator done");
        complete_run;
    end
endmodule
